/* File: common/lcs_consts.svh */
// Purpose: Offsets, field positions and reset values of the line interface status block
// Assumes: Included by the design file and the testbench
// Notes: Register index times four is the byte address on the bus
// Function
// - Live status bit 0 reads 1 while the receive side holds pattern lock.
// - Enabled pattern lock interrupt fires on every rise or fall of lock status.
// - Live and change registers work only in single-rail line mode; the enable register is written and read in any mode.
// - Change bit 6 sets when drive monitor status changed since last read.
// - Change bit 5 sets when FIFO limit status changed since last read.
// - Change bit 3 sets when loop-code detect status changed since last read.
// - Change bits hold until read, then clear; writing 1 to a bit also clears it; reset zero.
// - Change bits 7, 4 and 2 are unused and never interrupt.
// - Change bit 1 sets when loss-of-signal status changed; cleared on read.
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH
// ****************************************
// Register indices
// ****************************************
`define LCS_IDX_ENABLE 12'h0F04
`define LCS_IDX_LIVE 12'h0F05
`define LCS_IDX_LATCH 12'h0F06
`define LCS_IDX_CONFIG 12'h0F07
// ****************************************
// Field positions and masks
// ****************************************
`define LCS_BIT_PATTERN 0
`define LCS_BIT_LOS 1
`define LCS_BIT_LOOP 3
`define LCS_BIT_FIFO 5
`define LCS_BIT_DRIVE 6
`define LCS_IMPL_MASK 8'h6B
`define LCS_CFG_LIF_SINGLE 0
`define LCS_CFG_FRM_SINGLE 1
// ****************************************
// Reset values and answers
// ****************************************
`define LCS_RST_BYTE 8'h00
`define LCS_RST_CFG 2'h0
`define LCS_RESP_OKAY 2'h0
`define LCS_RESP_SLVERR 2'h2
`endif

/* File: common/lcs_pkg.sv */
// Purpose: Types of the line interface status block
// Assumes: Constants come from the header
// Notes: Whole module state is one packed struct
package lcs_pkg;
	// Complete register state of the block
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] enable;
		logic [1:0] cfg;
		logic [7:0] live;
		logic [7:0] latch;
		logic irq;
	} lcs_state_s;
endpackage : lcs_pkg

/* File: rtl/lcs_irq.sv */
// Purpose: Live status, change latch and interrupt for the line interface
// Assumes: Detector levels are synchronous to CLK; AXI4-Lite master on the bus
// Notes: Answers in two cycles after the request is offered
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "lcs_consts.svh"
module lcs_irq
	import lcs_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic PATTERN_LOCK_STATUS,
	input wire logic RX_LOS_STATUS,
	input wire logic LOOP_CODE_DETECT_STATUS,
	input wire logic FIFO_LIMIT_STATUS,
	input wire logic DRIVE_MONITOR_STATUS,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic IRQ
);
	// ****************************************
	// State and decode
	// ****************************************
	lcs_state_s st;
	lcs_state_s next_st;
	logic [7:0] in_vec;
	logic [7:0] set_vec;
	logic [7:0] wr_clr;
	logic rd_clr;
	logic single;
	logic [11:0] wr_idx;
	logic [11:0] rd_idx;
	logic wr_go;
	logic rd_go;

	// Detector levels gathered at their live status positions
	always_comb begin
		in_vec = `LCS_RST_BYTE;
		in_vec[`LCS_BIT_PATTERN] = PATTERN_LOCK_STATUS;
		in_vec[`LCS_BIT_LOS] = RX_LOS_STATUS;
		in_vec[`LCS_BIT_LOOP] = LOOP_CODE_DETECT_STATUS;
		in_vec[`LCS_BIT_FIFO] = FIFO_LIMIT_STATUS;
		in_vec[`LCS_BIT_DRIVE] = DRIVE_MONITOR_STATUS;
	end

	assign single = st.cfg[`LCS_CFG_LIF_SINGLE];
	assign wr_idx = S_AXI_AWADDR[13:2];
	assign rd_idx = S_AXI_ARADDR[13:2];
	assign wr_go = st.awready;
	assign rd_go = st.arready;

	// ****************************************
	// Next state
	// ****************************************
	// Bus handshakes, register writes, change latching and interrupt
	always_comb begin
		next_st = st;
		set_vec = `LCS_RST_BYTE;
		wr_clr = `LCS_RST_BYTE;
		rd_clr = 1'b0;
		// Live status only means something in single-rail mode
		next_st.live = single ? (in_vec & `LCS_IMPL_MASK) : `LCS_RST_BYTE;
		// Any edge of a live bit is a change event; reserved bits stay out
		if (single) begin
			set_vec = (next_st.live ^ st.live) & `LCS_IMPL_MASK;
		end
		// Write: take address and data together, answer one cycle later
		if (!st.bvalid && !st.awready && S_AXI_AWVALID && S_AXI_WVALID) begin
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		if (wr_go) begin
			next_st.awready = 1'b0;
			next_st.wready = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `LCS_RESP_OKAY;
			case (wr_idx)
				`LCS_IDX_ENABLE: begin
					if (S_AXI_WSTRB[0]) begin
						next_st.enable = S_AXI_WDATA[7:0] & `LCS_IMPL_MASK;
					end
				end
				`LCS_IDX_LATCH: begin
					if (S_AXI_WSTRB[0]) begin
						wr_clr = S_AXI_WDATA[7:0];
					end
				end
				`LCS_IDX_CONFIG: begin
					if (S_AXI_WSTRB[0]) begin
						next_st.cfg = S_AXI_WDATA[1:0];
					end
				end
				`LCS_IDX_LIVE: begin
					next_st.bresp = `LCS_RESP_OKAY; // Read-only, write ignored
				end
				default: begin
					next_st.bresp = `LCS_RESP_SLVERR;
				end
			endcase
		end
		if (st.bvalid && S_AXI_BREADY) begin
			next_st.bvalid = 1'b0;
		end
		// Read: accept, then present data with the registered answer
		if (!st.rvalid && !st.arready && S_AXI_ARVALID) begin
			next_st.arready = 1'b1;
		end
		if (rd_go) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = `LCS_RESP_OKAY;
			next_st.rdata = 32'h0000_0000;
			case (rd_idx)
				`LCS_IDX_ENABLE: begin
					next_st.rdata[7:0] = st.enable;
				end
				`LCS_IDX_LIVE: begin
					next_st.rdata[7:0] = st.live;
				end
				`LCS_IDX_LATCH: begin
					next_st.rdata[7:0] = st.latch;
					rd_clr = 1'b1;
				end
				`LCS_IDX_CONFIG: begin
					next_st.rdata[1:0] = st.cfg;
				end
				default: begin
					next_st.rresp = `LCS_RESP_SLVERR;
				end
			endcase
		end
		if (st.rvalid && S_AXI_RREADY) begin
			next_st.rvalid = 1'b0;
		end
		// Clear first, then set, so an event in the clearing cycle survives
		next_st.latch = st.latch & ~wr_clr;
		if (rd_clr) begin
			next_st.latch = `LCS_RST_BYTE;
		end
		next_st.latch = (next_st.latch | set_vec) & `LCS_IMPL_MASK;
		if (!single) begin
			next_st.latch = `LCS_RST_BYTE;
		end
		// Registered so the pin follows the latch with no extra delay
		next_st.irq = |(next_st.latch & next_st.enable);
	end

	// ****************************************
	// Registers
	// ****************************************
	// Whole state in one register bank
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops
	assign S_AXI_AWREADY = st.awready;
	assign S_AXI_WREADY = st.wready;
	assign S_AXI_BVALID = st.bvalid;
	assign S_AXI_BRESP = st.bresp;
	assign S_AXI_ARREADY = st.arready;
	assign S_AXI_RVALID = st.rvalid;
	assign S_AXI_RRESP = st.rresp;
	assign S_AXI_RDATA = st.rdata;
	assign IRQ = st.irq;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	// Lock level shows in live status one edge later
	a_live_pattern_lock: assert property (single && PATTERN_LOCK_STATUS
		|=> st.live[`LCS_BIT_PATTERN]) else $error("pattern lock not shown live");
	// A change is latched at the same edge; the first single-rail edge is left out,
	// since live starts from zero there and a falling level shows no edge
	a_pattern_edge_set: assert property (single && $past(single)
		&& $changed(PATTERN_LOCK_STATUS) |=> st.latch[`LCS_BIT_PATTERN])
		else $error("pattern edge not latched");
	a_non_single_idle: assert property (!single |=> st.latch == `LCS_RST_BYTE)
		else $error("latch active outside single-rail");
	a_drive_edge_set: assert property (single && $past(single)
		&& $changed(DRIVE_MONITOR_STATUS) |=> st.latch[`LCS_BIT_DRIVE])
		else $error("drive monitor edge lost");
	a_fifo_edge_set: assert property (single && $past(single)
		&& $changed(FIFO_LIMIT_STATUS) |=> st.latch[`LCS_BIT_FIFO])
		else $error("fifo limit edge lost");
	a_loop_edge_set: assert property (single && $past(single)
		&& $changed(LOOP_CODE_DETECT_STATUS) |=> st.latch[`LCS_BIT_LOOP])
		else $error("loop code edge lost");
	// Data stands in the cycle after the clearing edge, whatever the master's ready
	a_read_clears_latch: assert property (rd_clr && set_vec == `LCS_RST_BYTE
		|=> st.latch == `LCS_RST_BYTE && st.rvalid) else $error("read did not clear");
	a_reserved_quiet: assert property ((st.latch & ~`LCS_IMPL_MASK) == `LCS_RST_BYTE)
		else $error("reserved change bit set");
	a_los_edge_set: assert property (single && $past(single)
		&& $changed(RX_LOS_STATUS) |=> st.latch[`LCS_BIT_LOS])
		else $error("loss of signal edge lost");
	a_irq_tracks_latch: assert property (IRQ == |(st.latch & st.enable))
		else $error("interrupt out of step with latch");
endmodule : lcs_irq

/* File: verif/lcs_irq_tb.sv */
// Purpose: Self-checking bench for the line interface live status and change latch
// Assumes: AXI4-Lite master tasks; detector levels change at rising edges
// Notes: Byte address is the register index times four
`timescale 1ns/1ns
`include "lcs_consts.svh"
module lcs_irq_tb
	import lcs_pkg::*;
;
	localparam logic [15:0] A_EN = {2'b00, `LCS_IDX_ENABLE, 2'b00};
	localparam logic [15:0] A_LV = {2'b00, `LCS_IDX_LIVE, 2'b00};
	localparam logic [15:0] A_LT = {2'b00, `LCS_IDX_LATCH, 2'b00};
	localparam logic [15:0] A_CF = {2'b00, `LCS_IDX_CONFIG, 2'b00};
	localparam logic [1:0] OK = `LCS_RESP_OKAY;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [6:0] st = '0;
	logic [15:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d, m;
	int n_mismatch = 0, comparisons = 0, b;
	int bits[5] = '{0, 1, 3, 5, 6};
	// Free running 50 MHz clock
	always #10 clk = ~clk;
	lcs_irq u_lcs_irq (.CLK(clk), .SYS_RST(sys_rst), .PATTERN_LOCK_STATUS(st[0]),
		.RX_LOS_STATUS(st[1]), .LOOP_CODE_DETECT_STATUS(st[3]), .FIFO_LIMIT_STATUS(st[5]),
		.DRIVE_MONITOR_STATUS(st[6]), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.IRQ(irq));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task finish_test;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait; a hung handshake ends the run
	task tick(inout int n);
		@(posedge clk);
		n++;
		if (n > 40) begin
			n_mismatch++;
			$display("Error at %0t: timeout got %h expected %h", $time, n, 0);
			finish_test();
		end
	endtask : tick
	// Outputs are registered, so values read at the edge are the sampled ones
	task wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			tick(n);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		rs = bresp;
	endtask : wr
	task rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			tick(n);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		v = rdata;
		rs = rresp;
	endtask : rd
	task rc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] re);
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, re});
	endtask : rc
	// Detector level change, then time for live and latch to settle
	task set_st(input int i, input logic v);
		@(posedge clk);
		st[i] <= v;
		repeat (3) @(posedge clk);
	endtask : set_st
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		rc(A_EN, 0, OK);
		rc(A_LT, 0, OK);
		// Outside single-rail the pattern lock level stays hidden
		set_st(0, 1'b1);
		rc(A_LV, 0, OK);
		rc(A_LT, 0, OK);
		chk({31'h0, irq}, 0);
		set_st(0, 1'b0);
		wr(A_CF, 32'h0000_0003, r);
		wr(A_EN, 32'h0000_00FF, r);
		rc(A_EN, `LCS_IMPL_MASK, OK);
		$display("test reset_and_mode done");
		// Rise and fall of each status level, read and write clears
		foreach (bits[i]) begin
			b = bits[i];
			m = 32'h0000_0001 << b;
			set_st(b, 1'b1);
			chk({31'h0, irq}, 1);
			rc(A_LV, m, OK);
			rc(A_LT, m, OK);
			rc(A_LT, 0, OK);
			chk({31'h0, irq}, 0);
			set_st(b, 1'b0);
			wr(A_LT, ~m, r);
			rc(A_LT, m, OK);
			set_st(b, 1'b1);
			wr(A_LT, m, r);
			rc(A_LT, 0, OK);
			set_st(b, 1'b0);
			rc(A_LT, m, OK);
		end
		$display("test change_latch done");
		// Only enabled changes raise the request
		wr(A_EN, 32'h0000_0008, r);
		set_st(0, 1'b1);
		chk({31'h0, irq}, 0);
		set_st(3, 1'b1);
		chk({31'h0, irq}, 1);
		rc(A_LT, 32'h0000_0009, OK);
		chk({31'h0, irq}, 0);
		wr(A_LV, 32'h0000_00FF, r);
		chk({30'h0, r}, {30'h0, OK});
		rc(A_LV, 32'h0000_0009, OK);
		wr(16'h0040, 32'h0000_00FF, r);
		chk({30'h0, r}, {30'h0, `LCS_RESP_SLVERR});
		rc(16'h0040, 0, `LCS_RESP_SLVERR);
		// Leaving single-rail hides the levels and drops a pending change
		set_st(5, 1'b1);
		wr(A_CF, 32'h0000_0000, r);
		rc(A_LV, 0, OK);
		rc(A_LT, 0, OK);
		$display("test enable_and_access done");
		finish_test();
	end
endmodule : lcs_irq_tb
